// file: logic/sensor_cfg_regs.sv
// Self-test, rest, resolution and laser drive configuration registers
`timescale 1ns/1ps
`default_nettype none
`include "sensor_cfg_defines.svh"


module sensor_cfg_regs
	import sensor_cfg_pkg::*;
#(
	parameter int unsigned SELFTEST_CYCLES = `SELFTEST_CYCLES  // Self-test length in clocks
)
(
	input  wire logic        ref_clk_in,             // 10 MHz core clock
	input  wire logic        rst_b_in,               // Async reset, active low
	input  wire logic        ncs_b_in,               // Serial chip select, active low
	input  wire logic        sclk_in,                // Serial clock
	input  wire logic        mosi_in,                // Serial data in
	output var  logic        miso_out,               // Serial data out
	output var  logic        miso_oe_out,            // Serial data out enable
	input  wire logic        laser_pulse_in,         // Frame laser strobe, same clock
	input  wire logic [7:0]  laser_current_comp_in,  // Complement copy of current code
	input  wire logic [7:0]  laser_ctrl_comp_in,     // Complement copy of drive bits
	input  wire logic [31:0] selftest_result_in,     // Self-test result bytes
	output var  logic        selftest_busy_out,      // Self-test running
	output var  logic        sleep_level_one_out,    // Forced first rest level
	output var  logic        sleep_level_three_out,  // Forced third rest level
	output var  logic        resolution_800_out,     // 800 cpi selected
	output var  logic        laser_high_span_out,    // High current span
	output var  logic [7:0]  laser_current_code_out, // Laser current code
	output var  logic        laser_setting_ok_out,   // Both complement pairs match
	output var  logic        laser_calibrate_out,    // Continuous-on calibration
	output var  logic        laser_enable_pin_low_out // Laser enable, active low
);

	localparam int CW    = $clog2(SELFTEST_CYCLES + 1);
	localparam int NPAIR = 2;  // Drive bits that carry a complement copy
	localparam int PAIR_BIT [NPAIR] = '{`BIT_LASER_SPAN, `BIT_LASER_MATCH};

	// Refuse a self-test length the counter cannot serve
	if (SELFTEST_CYCLES < 1)
	begin : g_check
		$error("SELFTEST_CYCLES must be at least 1");
	end

	typedef struct packed {
		logic                busy;
		logic [CW-1:0]       cnt;
		logic [3:0][7:0]     signature;
		logic [7:0]          config_r;
		logic [7:0]          drive;
		logic [7:0]          current;
		logic                ok;
		logic                laser_n;
		logic                sleep_one;
		logic                sleep_three;
		logic                calib;
	} bank_state_s;

	bank_state_s      q;
	bank_state_s      d;
	reg_port_if       bus ();
	logic             pair_ok;
	logic             code_ok;
	logic [NPAIR-1:0] drive_bit_ok;
	logic [2:0]       cal;

	serial_reg_slave u_port (
		.ref_clk_in  (ref_clk_in),
		.rst_b_in    (rst_b_in),
		.ncs_b_in    (ncs_b_in),
		.sclk_in     (sclk_in),
		.mosi_in     (mosi_in),
		.miso_out    (miso_out),
		.miso_oe_out (miso_oe_out),
		.bus         (bus.slave)
	);

	// Port goes deaf while the self-test owns the sensor
	assign bus.block = q.busy;

	// Calibration code as stored, read by the laser drive decision
	assign cal = q.drive[`BIT_CAL_HI:`BIT_CAL_LO];

	// Current code against its copy; contents only, never write order
	assign code_ok = (q.current == ~laser_current_comp_in);

	// Each paired drive bit must oppose the same bit of its copy
	for (genvar p = 0; p < NPAIR; p++)
	begin : g_pair
		assign drive_bit_ok[p] = (q.drive[PAIR_BIT[p]]
			!= laser_ctrl_comp_in[PAIR_BIT[p]]);
	end

	// Either pair failing is enough to drop the laser and the flag
	assign pair_ok = code_ok && (&drive_bit_ok);

	// Read mux; the trigger register is write-only and reads zero
	always_comb
	begin
		case (bus.addr)
			`OFS_SIGNATURE_0,
			`OFS_SIGNATURE_1,
			`OFS_SIGNATURE_2,
			`OFS_SIGNATURE_3:
			begin
				// Four consecutive offsets, so the low address bits pick the byte
				bus.rdata = q.signature[bus.addr[1:0]];
			end
			`OFS_SENSOR_CONFIG:       bus.rdata = q.config_r;
			`OFS_LASER_DRIVE_CONTROL: bus.rdata = q.drive;
			`OFS_LASER_CURRENT:       bus.rdata = q.current;
			default:                  bus.rdata = 8'h00;
		endcase
	end

	// Register writes, self-test timer and laser outputs
	always_comb
	begin
		d = q;
		if (bus.wr_stb)
		begin
			case (bus.addr)
				`OFS_SELF_TEST_TRIGGER:
				begin
					if (bus.wdata[`BIT_SELF_TEST_GO])
					begin
						d.busy = 1'b1;
						d.cnt  = '0;
					end
				end
				`OFS_SENSOR_CONFIG:
				begin
					// Reserved bits are kept as written
					d.config_r = bus.wdata;
				end
				`OFS_LASER_DRIVE_CONTROL:
				begin
					// Calibration code stored whole; only 000 leaves it
					d.drive = bus.wdata;
				end
				`OFS_LASER_CURRENT:
				begin
					// Drives the laser only once the copy agrees
					d.current = bus.wdata;
				end
				default:
				begin
					// Unmapped offsets and the signatures ignore writes
					d.busy = q.busy;
				end
			endcase
		end
		// Fixed run window; results only published at the end
		if (q.busy)
		begin
			d.cnt = CW'(q.cnt + 1'b1);
			if (q.cnt == CW'(SELFTEST_CYCLES - 1))
			begin
				d.busy      = 1'b0;
				d.signature = selftest_result_in;
			end
		end
		// Flag follows the pair contents one cycle late
		d.ok = pair_ok;
		// Kill bit or failed pair forces the laser off ahead of calibration
		if (q.drive[`BIT_LASER_KILL] || !pair_ok)
			d.laser_n = 1'b1;
		else if (cal != 3'h0)
			d.laser_n = 1'b0;
		else
			d.laser_n = ~laser_pulse_in;
		// Decodes taken from the next contents, so they never lag the registers
		d.sleep_one   = (d.config_r[`BIT_SLEEP_HI:`BIT_SLEEP_LO]
			== `SLEEP_LEVEL_ONE);
		d.sleep_three = (d.config_r[`BIT_SLEEP_HI:`BIT_SLEEP_LO]
			== `SLEEP_LEVEL_THREE);
		d.calib       = (d.drive[`BIT_CAL_HI:`BIT_CAL_LO] != 3'h0);
	end

	// State register
	always_ff @(posedge ref_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			q           <= '0;
			q.signature <= {4{`RST_SIGNATURE}};
			q.config_r  <= `RST_SENSOR_CONFIG;
			q.drive     <= `RST_LASER_DRIVE_CONTROL;
			q.current   <= `RST_LASER_CURRENT;
			q.laser_n   <= 1'b1;
		end
		else
			q <= d;
	end

	// Outputs straight from the state register
	assign selftest_busy_out        = q.busy;
	assign sleep_level_one_out      = q.sleep_one;
	assign sleep_level_three_out    = q.sleep_three;
	assign resolution_800_out       = q.config_r[`BIT_RESOLUTION];
	assign laser_high_span_out      = q.drive[`BIT_LASER_SPAN];
	assign laser_current_code_out   = q.current;
	assign laser_setting_ok_out     = q.ok;
	assign laser_calibrate_out      = q.calib;
	assign laser_enable_pin_low_out = q.laser_n;

endmodule // sensor_cfg_regs

`default_nettype wire

// file: logic/sensor_cfg_defines.svh
// Register offsets, field positions, reset values and timing of the sensor configuration block
`ifndef SENSOR_CFG_DEFINES_SVH
`define SENSOR_CFG_DEFINES_SVH

// Register offsets (7-bit serial addresses)
`define OFS_SIGNATURE_0         7'h0C
`define OFS_SIGNATURE_1         7'h0D
`define OFS_SIGNATURE_2         7'h0E
`define OFS_SIGNATURE_3         7'h0F
`define OFS_SELF_TEST_TRIGGER   7'h10
`define OFS_SENSOR_CONFIG       7'h11
`define OFS_LASER_DRIVE_CONTROL 7'h1A
`define OFS_LASER_CURRENT       7'h1C

// Reset values
`define RST_SENSOR_CONFIG       8'h03
`define RST_LASER_DRIVE_CONTROL 8'h00
`define RST_LASER_CURRENT       8'h00
`define RST_SIGNATURE           8'h00

// Field positions
`define BIT_SELF_TEST_GO        0
`define BIT_RESOLUTION          7
`define BIT_SLEEP_HI            5
`define BIT_SLEEP_LO            4
`define BIT_LASER_SPAN          7
`define BIT_LASER_MATCH         5
`define BIT_CAL_HI              3
`define BIT_CAL_LO              1
`define BIT_LASER_KILL          0

// Forced sleep encodings
`define SLEEP_NORMAL            2'h0
`define SLEEP_LEVEL_ONE         2'h1
`define SLEEP_LEVEL_THREE       2'h3

// Timing
`define CLK_FREQ_KHZ            10000
`define SELFTEST_TIME_MS        250
`define SELFTEST_CYCLES         (`SELFTEST_TIME_MS * `CLK_FREQ_KHZ)

`endif

// file: logic/sensor_cfg_pkg.sv
// Types shared by the sensor configuration block
package sensor_cfg_pkg;

	// Serial frame phases, Gray coded along address -> write data; address -> read data flips both bits
	typedef enum logic [1:0] {
		ST_ADDR  = 2'b00,
		ST_WDATA = 2'b01,
		ST_RDATA = 2'b11
	} ser_phase_e;

	// Whole state of the serial slave
	typedef struct packed {
		logic [1:0] ncs_sync;
		logic [1:0] sclk_sync;
		logic [1:0] mosi_sync;
		logic       sclk_prev;
		ser_phase_e phase;
		logic [2:0] bit_cnt;
		logic [7:0] shift;
		logic [7:0] tx;
		logic       tx_pending;
		logic [6:0] addr;
		logic [7:0] wdata;
		logic       wr_stb;
		logic       miso;
		logic       miso_oe;
	} ser_state_s;

endpackage

// file: logic/reg_port_if.sv
// Register access path between serial slave and register bank
`timescale 1ns/1ps
`default_nettype none

interface reg_port_if;
	logic [6:0] addr;    // Register address
	logic [7:0] wdata;   // Write data
	logic       wr_stb;  // One-cycle write strobe
	logic [7:0] rdata;   // Read data for addr
	logic       block;   // Port locked out

	modport slave (output addr, output wdata, output wr_stb, input rdata, input block);
	modport bank  (input addr, input wdata, input wr_stb, output rdata, output block);
endinterface // reg_port_if

`default_nettype wire

// file: logic/serial_reg_slave.sv
// Four-wire serial slave, oversampled by the core clock
`timescale 1ns/1ps
`default_nettype none

module serial_reg_slave
	import sensor_cfg_pkg::*;
(
	input  wire logic  ref_clk_in,   // Core clock
	input  wire logic  rst_b_in,     // Async reset, active low
	input  wire logic  ncs_b_in,     // Chip select pin, active low
	input  wire logic  sclk_in,      // Serial clock pin
	input  wire logic  mosi_in,      // Serial data in pin
	output var  logic  miso_out,     // Serial data out
	output var  logic  miso_oe_out,  // Data out enable
	reg_port_if.slave  bus           // Register access
);

	ser_state_s q;
	ser_state_s d;
	logic       rise;
	logic       fall;
	logic [7:0] nb;

	// Edges seen only past the second sync stage
	assign rise = q.sclk_sync[1] & ~q.sclk_prev;
	assign fall = ~q.sclk_sync[1] & q.sclk_prev;
	assign nb   = {q.shift[6:0], q.mosi_sync[1]};

	// Frame decoder: address byte (bit 7 = write), then one data byte
	always_comb
	begin
		d = q;
		d.ncs_sync  = {q.ncs_sync[0], ncs_b_in};
		d.sclk_sync = {q.sclk_sync[0], sclk_in};
		d.mosi_sync = {q.mosi_sync[0], mosi_in};
		d.sclk_prev = q.sclk_sync[1];
		d.wr_stb    = 1'b0;
		// Locked out while the self-test runs, so stray traffic is dropped
		if (q.ncs_sync[1] || bus.block)
		begin
			d.phase      = ST_ADDR;
			d.bit_cnt    = 3'h0;
			d.miso_oe    = 1'b0;
			d.tx_pending = 1'b0;
		end
		else
		begin
			d.miso_oe = (q.phase == ST_RDATA);
			// Read data is fetched one cycle after the address settles
			if (q.tx_pending)
			begin
				d.tx         = bus.rdata;
				d.tx_pending = 1'b0;
			end
			case (q.phase)
				ST_ADDR, ST_WDATA:
				begin
					if (rise)
					begin
						d.shift   = nb;
						d.bit_cnt = q.bit_cnt + 3'h1;
						if (q.bit_cnt == 3'h7)
						begin
							if (q.phase == ST_WDATA)
							begin
								d.wdata  = nb;
								d.wr_stb = 1'b1;
								d.phase  = ST_ADDR;
							end
							else
							begin
								d.addr       = nb[6:0];
								d.phase      = nb[7] ? ST_WDATA : ST_RDATA;
								d.tx_pending = ~nb[7];
							end
						end
					end
				end
				ST_RDATA:
				begin
					// Shift out on falling, count master samples on rising
					if (fall)
					begin
						d.miso = q.tx[7];
						d.tx   = {q.tx[6:0], 1'b0};
					end
					if (rise)
					begin
						d.bit_cnt = q.bit_cnt + 3'h1;
						if (q.bit_cnt == 3'h7)
							d.phase = ST_ADDR;
					end
				end
				default:
				begin
					d.phase = ST_ADDR;
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge ref_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			q           <= '0;
			q.ncs_sync  <= 2'h3;
			// Clock taken as idle high, so no false edge after reset
			q.sclk_sync <= 2'h3;
			q.sclk_prev <= 1'b1;
			q.phase     <= ST_ADDR;
		end
		else
			q <= d;
	end

	assign bus.addr    = q.addr;
	assign bus.wdata   = q.wdata;
	assign bus.wr_stb  = q.wr_stb;
	assign miso_out    = q.miso;
	assign miso_oe_out = q.miso_oe;

endmodule // serial_reg_slave

`default_nettype wire

// file: verif/sensor_cfg_props.sv
// Port assertions for the sensor configuration block
`timescale 1ns/1ps
`default_nettype none
module sensor_cfg_props #(
	parameter int unsigned SELFTEST_CYCLES = 400 // Self-test length in clocks
)(
	input wire logic       ref_clk_in,              // Core clock
	input wire logic       rst_b_in,                // Reset, active low
	input wire logic       miso_oe_out,             // Data out enable
	input wire logic [7:0] laser_current_comp_in,   // Code complement
	input wire logic [7:0] laser_ctrl_comp_in,      // Drive complement
	input wire logic       selftest_busy_out,       // Self-test running
	input wire logic       sleep_level_one_out,     // Rest one
	input wire logic       sleep_level_three_out,   // Rest three
	input wire logic       resolution_800_out,      // 800 cpi
	input wire logic       laser_high_span_out,     // High span
	input wire logic [7:0] laser_current_code_out,  // Current code
	input wire logic       laser_setting_ok_out,    // Pairs match
	input wire logic       laser_enable_pin_low_out // Enable, active low
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_b_in);
	logic [31:0] busy_cnt_q;
	// Busy cycles so far; too long for a repetition
	always_ff @(posedge ref_clk_in or negedge rst_b_in)
		if (!rst_b_in)
			busy_cnt_q <= 32'h0;
		else
			busy_cnt_q <= selftest_busy_out ? busy_cnt_q + 32'h1 : 32'h0;
	sequence s_busy_end;
		$fell(selftest_busy_out);
	endsequence
	a_busy_exact_len: assert property (s_busy_end |-> busy_cnt_q == SELFTEST_CYCLES)
		else $error("self-test window length wrong");
	a_busy_no_oe: assert property (selftest_busy_out |-> !miso_oe_out)
		else $error("data out driven during self-test");
	a_busy_cfg_frozen: assert property (selftest_busy_out && $past(selftest_busy_out)
		|-> $stable(resolution_800_out) && $stable(laser_current_code_out))
		else $error("register changed during self-test");
	a_sleep_one_hot: assert property (!(sleep_level_one_out && sleep_level_three_out))
		else $error("both rest levels forced");
	a_bad_pin_high: assert property (!laser_setting_ok_out |-> laser_enable_pin_low_out)
		else $error("laser enabled with failed pair");
	a_code_fail_low: assert property ($past(laser_current_code_out != ~laser_current_comp_in)
		|-> !laser_setting_ok_out)
		else $error("valid flag set with code mismatch");
	a_span_fail_low: assert property ($past(laser_high_span_out == laser_ctrl_comp_in[7])
		|-> !laser_setting_ok_out)
		else $error("valid flag set with span mismatch");
	a_ok_needs_match: assert property (laser_setting_ok_out |-> $past(laser_current_code_out
		== ~laser_current_comp_in && laser_high_span_out != laser_ctrl_comp_in[7]))
		else $error("valid flag without matching pairs");
endmodule // sensor_cfg_props
`default_nettype wire

// file: verif/ser_master_model.sv
// Serial port master standing in for the controller
`timescale 1ns/1ps
`default_nettype none
module ser_master_model (
	input  wire logic clk_in,    // Core clock for pacing
	input  wire logic miso_in,   // Resolved data line
	output var  logic ncs_b_out, // Chip select, active low
	output var  logic sclk_out,  // Serial clock, idle high
	output var  logic mosi_out   // Serial data out
);
	initial {ncs_b_out, sclk_out, mosi_out} = 3'b110;
	// Half serial period, four core cycles for 400 ns
	task automatic half();
		repeat (4) @(posedge clk_in);
		#5;
	endtask
	// Byte MSB first: drive on fall, read at rise
	task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--)
		begin
			sclk_out = 1'b0;
			mosi_out = tx[i];
			half();
			rx[i] = miso_in;
			sclk_out = 1'b1;
			half();
		end
	endtask
	// Address byte then data byte in one select window
	task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d,
		output logic [7:0] rd);
		logic [7:0] junk;
		ncs_b_out = 1'b0;
		half();
		byte_io({w, a}, junk);
		byte_io(d, rd);
		mosi_out = ~mosi_out; // Stale data never looks held
		half();
		ncs_b_out = 1'b1;
		half();
		half();
	endtask
endmodule // ser_master_model
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench for the sensor configuration block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int unsigned STC = 400; // Shortened self-test
	logic        clk = 1'b0, rst_b = 1'b0, pulse = 1'b0, tgl_q = 1'b0;
	logic [7:0]  ccomp = 8'hFF, dcomp = 8'hFF, drv = 8'h00, cur = 8'h00, v;
	logic [31:0] res = 32'h0;
	logic [7:0]  dtab [6] = '{8'h01, 8'h03, 8'hA0, 8'h0E, 8'h20, 8'h00};
	int          fail_count = 0, n_checks = 0;
	wire logic   ncs_b, sclk, mosi, miso, miso_oe, miso_w, busy, s1, s3, r800, span, ok, cal, pin_b;
	wire logic [7:0] code;
	always #50 clk = ~clk;
	// Released data line shows a changing pattern
	always @(posedge clk) tgl_q <= ~tgl_q;
	assign miso_w = miso_oe ? miso : tgl_q;
	sensor_cfg_regs #(.SELFTEST_CYCLES(STC)) dut_u (.ref_clk_in(clk), .rst_b_in(rst_b),
		.ncs_b_in(ncs_b), .sclk_in(sclk), .mosi_in(mosi), .miso_out(miso),
		.miso_oe_out(miso_oe), .laser_pulse_in(pulse), .laser_current_comp_in(ccomp),
		.laser_ctrl_comp_in(dcomp), .selftest_result_in(res), .selftest_busy_out(busy),
		.sleep_level_one_out(s1), .sleep_level_three_out(s3), .resolution_800_out(r800),
		.laser_high_span_out(span), .laser_current_code_out(code),
		.laser_setting_ok_out(ok), .laser_calibrate_out(cal),
		.laser_enable_pin_low_out(pin_b));
	ser_master_model m_u (.clk_in(clk), .miso_in(miso_w), .ncs_b_out(ncs_b),
		.sclk_out(sclk), .mosi_out(mosi));
	task print_verdict();
		if (fail_count == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("mismatch t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk);
		#5;
	endtask
	task wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] x;
		m_u.xfer(1'b1, a, d, x);
	endtask
	task rdc(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] x;
		m_u.xfer(1'b0, a, 8'h00, x);
		chk(x, e);
	endtask
	// Bounded wait for the self-test flag
	task wt(input logic lvl);
		for (int n = 0; n < 1000 && busy !== lvl; n++) tick(1);
		if (busy !== lvl)
		begin
			fail_count++;
			print_verdict();
		end
	endtask
	function automatic logic exp_ok(input logic [7:0] c);
		return c == ~ccomp && drv[7] != dcomp[7] && drv[5] != dcomp[5];
	endfunction
	// Kill or bad pair wins over calibration
	function automatic logic exp_pin(input logic k);
		if (!k || drv[0]) return 1'b1;
		if (drv[3:1] != 3'h0) return 1'b0;
		return ~pulse;
	endfunction
	task outs(input logic [7:0] c);
		chk({ok, pin_b, span, cal, code}, {exp_ok(c), exp_pin(exp_ok(c)), drv[7],
			drv[3:1] != 3'h0, c});
	endtask
	initial
	begin
		void'($urandom(32'hBB53B208));
		tick(16);
		rst_b = 1'b1;
		tick(4);
		rdc(7'h11, 8'h03);
		rdc(7'h1A, 8'h00);
		rdc(7'h1C, 8'h00);
		rdc(7'h10, 8'h00);
		rdc(7'h05, 8'h00);
		outs(cur);
		// Complement set before or after the code, one left wrong
		for (int i = 0; i < 6; i++)
		begin
			cur = 8'($urandom);
			if (i[0]) ccomp = ~cur;
			wr(7'h1C, cur);
			ccomp = (i == 4) ? ~cur ^ 8'h10 : ~cur;
			tick(2);
			rdc(7'h1C, cur);
			outs(cur);
		end
		// Every rest code, no motion simulated meanwhile
		for (int i = 0; i < 4; i++)
		begin
			v = 8'($urandom);
			v[5:4] = i[1:0];
			wr(7'h11, v);
			chk({s1, s3, r800}, {v[5:4] == 2'h1, v[5:4] == 2'h3, v[7]});
			rdc(7'h11, v);
		end
		// Kill, calibration, span and a broken drive pair
		foreach (dtab[i])
		begin
			drv = dtab[i];
			dcomp = (i == 4) ? 8'hFF : ~drv;
			pulse = ~i[0];
			wr(7'h1A, drv);
			rdc(7'h1A, drv);
			outs(cur);
		end
		wr(7'h05, 8'hFF);
		rdc(7'h1A, 8'h00);
		res = $urandom;
		res[7:0] = 8'h05;
		wr(7'h10, 8'h01);
		wt(1'b1);
		wr(7'h11, 8'h80);
		wt(1'b0);
		for (int i = 0; i < 4; i++) rdc(7'(7'h0C + i), res[8 * i +: 8]);
		rdc(7'h11, v);
		rst_b = 1'b0;
		tick(16);
		rst_b = 1'b1;
		tick(4);
		rdc(7'h0C, 8'h00);
		rdc(7'h1C, 8'h00);
		print_verdict();
	end
endmodule // tb_top
bind sensor_cfg_regs sensor_cfg_props #(.SELFTEST_CYCLES(SELFTEST_CYCLES)) u_props (
	.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .miso_oe_out(miso_oe_out),
	.laser_current_comp_in(laser_current_comp_in), .laser_ctrl_comp_in(laser_ctrl_comp_in),
	.selftest_busy_out(selftest_busy_out), .sleep_level_one_out(sleep_level_one_out),
	.sleep_level_three_out(sleep_level_three_out), .resolution_800_out(resolution_800_out),
	.laser_high_span_out(laser_high_span_out), .laser_current_code_out(laser_current_code_out),
	.laser_setting_ok_out(laser_setting_ok_out),
	.laser_enable_pin_low_out(laser_enable_pin_low_out));
`default_nettype wire
